/* File: rtl/srp_device.sv */
// Device end: serial slave with metering register file
//
// Chosen here: the serial register port.
`timescale 1ns/1ps
module srp_device
   import srp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   srp_link_if.device link,
   input wire logic [23:0] wave_current, // Current channel sample
   input wire logic [23:0] wave_voltage, // Voltage channel sample
   input wire logic [23:0] wave_power, // Active power sample
   input wire logic [23:0] active_power, // Added per energy tick
   input wire logic [23:0] apparent_power,
   input wire logic [23:0] reactive_power,
   input wire logic energy_tick, // Accumulation enable pulse
   input wire logic half_cycle, // Line half cycle pulse
   input wire logic [15:0] half_cycle_count, // Half cycles per line window
   output logic [15:0] operating_mode_q // Mode register contents
);
   typedef enum logic [1:0] {
      SRP_ST_CMD = 2'b00, // Awaiting command byte
      SRP_ST_WR = 2'b01, // Shifting write data
      SRP_ST_RD = 2'b10, // Shifting read data
      SRP_ST_DONE = 2'b11 // Write complete, back to command state next cycle
   } srp_state_type;

   // Pin synchronisers
   logic [1:0] sclk_s_q, cs_s_q, din_s_q;
   logic sclk_q, cs_q; // Delayed copies for edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s_q <= 2'b11; // Idle high, so no false edge after reset
         cs_s_q <= 2'b11;
         din_s_q <= 2'b00;
         sclk_q <= 1'b1;
         cs_q <= 1'b1;
      end else begin
         sclk_s_q <= {sclk_s_q[0], link.sclk};
         cs_s_q <= {cs_s_q[0], link.cs_n};
         din_s_q <= {din_s_q[0], link.din};
         sclk_q <= sclk_s_q[1];
         cs_q <= cs_s_q[1];
      end
   end
   logic sclk_rise, sclk_fall, cs_fall, cs_rise, selected;
   assign sclk_rise = sclk_s_q[1] & ~sclk_q;
   assign sclk_fall = ~sclk_s_q[1] & sclk_q;
   assign cs_fall = ~cs_s_q[1] & cs_q;
   assign cs_rise = cs_s_q[1] & ~cs_q;
   assign selected = ~cs_s_q[1];

   srp_state_type state_q;
   logic [7:0] cmd_q; // Command shift stage
   logic [7:0] wbyte_q; // Write byte shift stage
   logic [2:0] bit_q; // Bit within byte
   logic [1:0] byte_q; // Bytes left
   logic [5:0] addr_q; // Latched address
   logic [23:0] rshift_q; // Read shifter
   logic [4:0] rbits_q; // Read bits left
   logic clr_rc_q; // Clear-on-read request pulse
   logic commit_q; // Committed byte pending
   logic [7:0] commit_data_q;
   logic [1:0] commit_idx_q; // Byte lane, 0 = least
   logic [$clog2(SRP_COMMIT_CYC+1)-1:0] commit_cnt_q;
   logic [23:0] waveform_q, aen_q, aen_rc_q, laen_q, vaen_q, vaen_rc_q, lvaen_q, lvaren_q;

   // Read mux of the register file
   function automatic logic [23:0] srp_read(input logic [5:0] a);
      case (a)
         SRP_ADDR_WAVEFORM: srp_read = waveform_q;
         SRP_ADDR_ACT_EN: srp_read = aen_q;
         SRP_ADDR_ACT_EN_RC: srp_read = aen_rc_q;
         SRP_ADDR_LINE_ACT: srp_read = laen_q;
         SRP_ADDR_APP_EN: srp_read = vaen_q;
         SRP_ADDR_APP_EN_RC: srp_read = vaen_rc_q;
         SRP_ADDR_LINE_APP: srp_read = lvaen_q;
         SRP_ADDR_LINE_REACT: srp_read = lvaren_q;
         SRP_ADDR_MODE: srp_read = {8'h00, operating_mode_q};
         default: srp_read = 24'h000000;
      endcase
   endfunction

   // Serial protocol engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SRP_ST_CMD;
         cmd_q <= 8'h00;
         wbyte_q <= 8'h00;
         bit_q <= 3'h0;
         byte_q <= 2'h0;
         addr_q <= 6'h00;
         rshift_q <= 24'h000000;
         rbits_q <= 5'h00;
         clr_rc_q <= 1'b0;
         commit_q <= 1'b0;
         commit_data_q <= 8'h00;
         commit_idx_q <= 2'h0;
         link.dout <= 1'b0;
         link.dout_oe <= 1'b0;
      end else begin
         clr_rc_q <= 1'b0;
         commit_q <= 1'b0;
         if (cs_fall) begin
            state_q <= SRP_ST_CMD;
            bit_q <= 3'h0;
         end else if (cs_rise || !selected) begin
            link.dout_oe <= 1'b0;
            state_q <= SRP_ST_CMD;
            bit_q <= 3'h0; // Partial write byte dropped
         end else begin
            case (state_q)
               SRP_ST_CMD: if (sclk_fall) begin
                  cmd_q <= {cmd_q[6:0], din_s_q[1]};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     addr_q <= {cmd_q[SRP_ADDR_BITS-2:0], din_s_q[1]};
                     byte_q <= srp_len({cmd_q[SRP_ADDR_BITS-2:0], din_s_q[1]});
                     if (cmd_q[SRP_DIR_BIT-1]) begin
                        state_q <= SRP_ST_WR;
                     end else begin
                        // Snapshot whole register for a stable read
                        rshift_q <= srp_read({cmd_q[SRP_ADDR_BITS-2:0], din_s_q[1]}) <<
                           (5'd8 * (5'd3 - {3'h0, srp_len({cmd_q[SRP_ADDR_BITS-2:0], din_s_q[1]})}));
                        rbits_q <= {srp_len({cmd_q[SRP_ADDR_BITS-2:0], din_s_q[1]}), 3'h0};
                        state_q <= SRP_ST_RD;
                     end
                  end
               end
               SRP_ST_WR: if (sclk_fall) begin
                  wbyte_q <= {wbyte_q[6:0], din_s_q[1]};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     commit_q <= 1'b1; // Hand byte to commit stage
                     commit_data_q <= {wbyte_q[6:0], din_s_q[1]};
                     commit_idx_q <= byte_q - 2'h1; // First byte is most significant
                     byte_q <= byte_q - 2'h1;
                     if (byte_q == 2'h1) state_q <= SRP_ST_DONE;
                  end
               end
               SRP_ST_RD: begin
                  if (sclk_rise && rbits_q != 5'h00) begin
                     link.dout_oe <= 1'b1;
                     link.dout <= rshift_q[SRP_DATA_BITS-1];
                     rshift_q <= {rshift_q[SRP_DATA_BITS-2:0], 1'b0};
                     rbits_q <= rbits_q - 5'h01;
                  end else if (sclk_fall && rbits_q == 5'h00) begin
                     link.dout_oe <= 1'b0;
                     clr_rc_q <= 1'b1;
                     state_q <= SRP_ST_CMD;
                     bit_q <= 3'h0;
                  end
               end
               SRP_ST_DONE: begin
                  state_q <= SRP_ST_CMD; // Next command byte follows
                  bit_q <= 3'h0;
               end
               default: state_q <= SRP_ST_CMD;
            endcase
         end
      end
   end

   // Commit stage: finite delay before the byte reaches the register
   logic wr_go;
   assign wr_go = commit_cnt_q == 1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         commit_cnt_q <= '0;
      end else if (commit_q) begin
         commit_cnt_q <= ($clog2(SRP_COMMIT_CYC+1))'(SRP_COMMIT_CYC);
      end else if (commit_cnt_q != 0) begin
         commit_cnt_q <= commit_cnt_q - 1'b1;
      end
   end

   // Mode register, first byte to bits 15:8, second byte to bits 7:0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operating_mode_q <= SRP_MODE_RESET;
      end else if (wr_go && addr_q == SRP_ADDR_MODE) begin
         if (commit_idx_q == 2'h1) operating_mode_q[15:8] <= commit_data_q;
         else if (commit_idx_q == 2'h0) operating_mode_q[7:0] <= commit_data_q;
      end
   end

   // Waveform source chosen by mode bits 14:13
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         waveform_q <= 24'h000000;
      end else begin
         case (operating_mode_q[SRP_MODE_WAVE_HI:SRP_MODE_WAVE_LO])
            2'b00: waveform_q <= wave_power;
            2'b10: waveform_q <= wave_current;
            2'b11: waveform_q <= wave_voltage;
            default: waveform_q <= 24'h000000;
         endcase
      end
   end

   // Running and clear-on-read energy accumulators
   logic rd_rc_a, rd_rc_va;
   assign rd_rc_a = clr_rc_q && addr_q == SRP_ADDR_ACT_EN_RC;
   assign rd_rc_va = clr_rc_q && addr_q == SRP_ADDR_APP_EN_RC;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aen_q <= 24'h000000;
         vaen_q <= 24'h000000;
         aen_rc_q <= 24'h000000;
         vaen_rc_q <= 24'h000000;
      end else begin
         if (energy_tick) aen_q <= aen_q + active_power;
         if (energy_tick) vaen_q <= vaen_q + apparent_power;
         // A tick in the clear cycle starts the new total
         if (rd_rc_a) aen_rc_q <= energy_tick ? active_power : 24'h000000;
         else if (energy_tick) aen_rc_q <= aen_rc_q + active_power;
         if (rd_rc_va) vaen_rc_q <= energy_tick ? apparent_power : 24'h000000;
         else if (energy_tick) vaen_rc_q <= vaen_rc_q + apparent_power;
      end
   end

   // Line accumulation over half_cycle_count half cycles
   logic [15:0] hc_q;
   logic [23:0] la_acc_q, lva_acc_q, lvar_acc_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hc_q <= 16'h0000;
         la_acc_q <= 24'h000000;
         lva_acc_q <= 24'h000000;
         lvar_acc_q <= 24'h000000;
         laen_q <= 24'h000000;
         lvaen_q <= 24'h000000;
         lvaren_q <= 24'h000000;
      end else if (half_cycle && hc_q + 16'h0001 >= half_cycle_count) begin
         hc_q <= 16'h0000; // Window closes: publish totals
         laen_q <= la_acc_q;
         lvaen_q <= lva_acc_q;
         lvaren_q <= lvar_acc_q;
         la_acc_q <= 24'h000000;
         lva_acc_q <= 24'h000000;
         lvar_acc_q <= 24'h000000;
      end else begin
         if (half_cycle) hc_q <= hc_q + 16'h0001;
         if (energy_tick) begin
            la_acc_q <= la_acc_q + active_power;
            lva_acc_q <= lva_acc_q + apparent_power;
            lvar_acc_q <= lvar_acc_q + reactive_power;
         end
      end
   end
endmodule // srp_device

/* File: rtl/srp_pkg.sv */
// Package of constants shared by both ends of the serial register port
package srp_pkg;
   localparam int SRP_BYTE_BITS = 8; // Bits per byte on the link
   localparam int SRP_ADDR_BITS = 6; // Address field of the command byte
   localparam int SRP_DATA_BITS = 24; // Widest register
   localparam int SRP_DIR_BIT = 7; // Command bit that marks a write
   localparam int SRP_CLK_MHZ = 100; // pclk rate
   localparam int SRP_BYTE_SPACING_US = 4; // byte_spacing_time
   localparam int SRP_WRITE_TO_READ_US = 4; // write_to_read_gap
   localparam int SRP_BYTE_SPACING_CYC = SRP_BYTE_SPACING_US * SRP_CLK_MHZ;
   localparam int SRP_WRITE_TO_READ_CYC = SRP_WRITE_TO_READ_US * SRP_CLK_MHZ;
   localparam int SRP_COMMIT_CYC = 4; // Internal byte commit delay
   localparam int SRP_SCLK_HALF = 4; // Host divider: half period in pclk cycles
   localparam int SRP_MODE_WAVE_LO = 13; // Waveform source select field
   localparam int SRP_MODE_WAVE_HI = 14;
   // Register map
   localparam logic [5:0] SRP_ADDR_WAVEFORM = 6'h01;
   localparam logic [5:0] SRP_ADDR_ACT_EN = 6'h02;
   localparam logic [5:0] SRP_ADDR_ACT_EN_RC = 6'h03;
   localparam logic [5:0] SRP_ADDR_LINE_ACT = 6'h04;
   localparam logic [5:0] SRP_ADDR_APP_EN = 6'h05;
   localparam logic [5:0] SRP_ADDR_APP_EN_RC = 6'h06;
   localparam logic [5:0] SRP_ADDR_LINE_APP = 6'h07;
   localparam logic [5:0] SRP_ADDR_LINE_REACT = 6'h08;
   localparam logic [5:0] SRP_ADDR_MODE = 6'h09;
   localparam logic [15:0] SRP_MODE_RESET = 16'h000c;
   // Host APB register offsets
   localparam logic [7:0] SRP_APB_CMD = 8'h00; // [7:0] command, [8] start
   localparam logic [7:0] SRP_APB_WDATA = 8'h04; // Write data, right justified
   localparam logic [7:0] SRP_APB_RDATA = 8'h08; // Read data
   localparam logic [7:0] SRP_APB_STATUS = 8'h0c; // [0] busy
   localparam logic [7:0] SRP_APB_LEN = 8'h10; // Byte count 1..3
   localparam int SRP_START_BIT = 8;
   // Byte width of a register
   function automatic logic [1:0] srp_len(input logic [5:0] a);
      srp_len = (a == SRP_ADDR_MODE) ? 2'h2 : 2'h3;
   endfunction
endpackage

/* File: rtl/srp_link_if.sv */
// Interface carrying the four serial link wires between host and device
`timescale 1ns/1ps
interface srp_link_if;
   logic sclk; // Serial clock from host
   logic cs_n; // Chip select, active low
   logic din; // Host to device data
   logic dout; // Device output value
   logic dout_oe; // Device drives dout
   logic dout_wire; // Line as the host sees it
   // Released line shows the inverse, so a late sample is caught
   assign dout_wire = dout_oe ? dout : ~dout;
   modport device (input sclk, input cs_n, input din, output dout, output dout_oe);
   modport host (output sclk, output cs_n, output din, input dout_wire);
endinterface

/* File: rtl/srp_host.sv */
// Host end: APB controlled serial master
`timescale 1ns/1ps
module srp_host
   import srp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   srp_link_if.host link
);
   typedef enum logic [2:0] {
      SRP_H_IDLE = 3'b000, // Nothing to do
      SRP_H_SHIFT = 3'b001, // Clocking a byte
      SRP_H_GAP = 3'b010, // Spacing before next byte
      SRP_H_END = 3'b011 // Frame close
   } srp_hstate_type;

   logic [7:0] cmd_q; // Command byte
   logic [23:0] wdata_q; // Write data
   logic [23:0] rdata_q; // Received data
   logic [1:0] len_q; // Data bytes
   logic busy_q;
   logic start;
   srp_hstate_type st_q;
   logic [2:0] div_q; // SCLK divider
   logic [3:0] half_q; // Half periods left in byte
   logic [1:0] bytes_q; // Data bytes left, command excluded
   logic [7:0] sh_q; // Output shifter
   logic [9:0] gap_q; // Spacing counter
   logic [1:0] ds_q; // dout synchroniser
   logic data_q; // Command byte is out, data bytes follow
   logic [7:0] next_byte; // Byte sent after the coming gap

   // Command first, then write data from the top lane down
   always_comb begin
      case (bytes_q)
         2'h3: next_byte = wdata_q[23:16];
         2'h2: next_byte = wdata_q[15:8];
         default: next_byte = wdata_q[7:0];
      endcase
      if (!data_q) next_byte = cmd_q;
   end
   logic access;
   assign access = psel & penable;
   assign start = access & pwrite & paddr == SRP_APB_CMD & pwdata[SRP_START_BIT] & ~busy_q;

   // APB slave, zero wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         cmd_q <= 8'h00;
         wdata_q <= 24'h000000;
         len_q <= 2'h3;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               SRP_APB_CMD: prdata <= {24'h000000, cmd_q};
               SRP_APB_WDATA: prdata <= {8'h00, wdata_q};
               SRP_APB_RDATA: prdata <= {8'h00, rdata_q};
               SRP_APB_STATUS: prdata <= {31'h00000000, busy_q};
               SRP_APB_LEN: prdata <= {30'h00000000, len_q};
               default: begin
                  prdata <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (access && pwrite && !busy_q) begin
            if (paddr == SRP_APB_CMD) cmd_q <= pwdata[7:0];
            if (paddr == SRP_APB_WDATA) wdata_q <= pwdata[23:0];
            if (paddr == SRP_APB_LEN && pwdata[1:0] != 2'h0) len_q <= pwdata[1:0];
         end
      end
   end

   // Serial engine: din moves on rising SCLK, device samples on falling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= SRP_H_IDLE;
         busy_q <= 1'b0;
         data_q <= 1'b0;
         link.sclk <= 1'b1;
         link.cs_n <= 1'b1;
         link.din <= 1'b0;
         div_q <= 3'h0;
         half_q <= 4'h0;
         bytes_q <= 2'h0;
         sh_q <= 8'h00;
         gap_q <= 10'h000;
         ds_q <= 2'b00;
         rdata_q <= 24'h000000;
      end else begin
         ds_q <= {ds_q[0], link.dout_wire};
         case (st_q)
            SRP_H_IDLE: if (start) begin
               busy_q <= 1'b1;
               data_q <= 1'b0; // Command byte goes first
               link.cs_n <= 1'b0;
               bytes_q <= len_q;
               rdata_q <= 24'h000000; // Short reads come back right justified
               gap_q <= 10'(SRP_WRITE_TO_READ_CYC); // Quiet time before any command
               st_q <= SRP_H_GAP;
            end
            SRP_H_SHIFT: begin
               div_q <= div_q + 3'h1;
               if (div_q == 3'(SRP_SCLK_HALF - 1)) begin
                  div_q <= 3'h0;
                  link.sclk <= ~link.sclk;
                  if (!link.sclk) begin
                     // Rising SCLK: next bit out, previous read bit
                     link.din <= sh_q[7];
                     sh_q <= {sh_q[6:0], 1'b0};
                     if (data_q && !cmd_q[SRP_DIR_BIT]) rdata_q <= {rdata_q[22:0], ds_q[1]};
                  end
                  if (half_q == 4'h0) begin
                     data_q <= 1'b1; // Command byte is out
                     gap_q <= 10'(SRP_BYTE_SPACING_CYC); // Byte spacing
                     st_q <= SRP_H_GAP;
                  end else begin
                     half_q <= half_q - 4'h1;
                  end
               end
            end
            SRP_H_GAP: begin
               gap_q <= gap_q - 10'h001;
               if (gap_q == 10'h000) begin
                  if (data_q && bytes_q == 2'h0) begin
                     st_q <= SRP_H_END;
                  end else begin
                     if (data_q) bytes_q <= bytes_q - 2'h1;
                     link.din <= next_byte[7]; // First bit set up before first fall
                     sh_q <= {next_byte[6:0], 1'b0};
                     half_q <= 4'hf;
                     div_q <= 3'h0;
                     st_q <= SRP_H_SHIFT;
                  end
               end
            end
            SRP_H_END: begin
               link.cs_n <= 1'b1;
               busy_q <= 1'b0;
               st_q <= SRP_H_IDLE;
            end
            default: st_q <= SRP_H_IDLE;
         endcase
      end
   end
endmodule // srp_host

/* File: sim/srp_link_asserts.sv */
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/1ps
module srp_link_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [5:0] fall_cnt; // Serial clock falls in this frame
   logic [9:0] gap_q; // Cycles since last byte ended, saturating

   // Count falling serial clock edges, cleared between frames
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall_cnt <= 6'h0;
      end else if (cs_n) begin
         fall_cnt <= 6'h0;
      end else if ($fell(sclk)) begin
         fall_cnt <= fall_cnt + 6'h1;
      end
   end

   // Time since the eighth fall of the last byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= 10'h3ff;
      end else if ($fell(sclk) && fall_cnt[2:0] == 3'h7) begin
         gap_q <= 10'h0;
      end else if (gap_q != 10'h3ff) begin
         gap_q <= gap_q + 10'h1;
      end
   end

   sclk_idle_a: assert property (cs_n |-> sclk)
      else $error("serial clock moved outside a frame");
   din_launch_a: assert property (!cs_n && $changed(din) |-> sclk)
      else $error("data in changed while serial clock low");
   frame_bytes_a: assert property ($rose(cs_n) |-> fall_cnt[2:0] == 3'h0)
      else $error("frame ended inside a byte");
   oe_first_a: assert property ($rose(dout_oe) |-> sclk && !cs_n && fall_cnt == 6'd8)
      else $error("output driven before command byte done");
   dout_rise_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> sclk)
      else $error("read bit changed while serial clock low");
   oe_last_a: assert property ($fell(dout_oe) && !cs_n |-> !sclk && (fall_cnt == 6'd24 || fall_cnt == 6'd32))
      else $error("output released at wrong bit");
   cs_release_a: assert property ($rose(cs_n) |-> ##[0:4] !dout_oe)
      else $error("output still driven after deselect");
   idle_oe_a: assert property (cs_n [*5] |-> !dout_oe)
      else $error("output driven while deselected");
   byte_gap_a: assert property ($fell(sclk) && fall_cnt[2:0] == 3'h7 && gap_q != 10'h3ff |-> gap_q >= 10'd399)
      else $error("byte ended too soon after previous byte");
endmodule // srp_link_asserts

/* File: sim/serial_register_port_tb_top.sv */
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module serial_register_port_tb_top;
   import srp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, energy_tick, half_cycle; // Bus and device controls
   logic [7:0] paddr; // Bus address
   logic [31:0] pwdata, prdata; // Bus data
   logic [23:0] wave_current, wave_voltage, wave_power, active_power, apparent_power, reactive_power; // Device inputs
   logic [15:0] half_cycle_count, mode_q; // Line window and mode register
   logic [23:0] rd; // Last link read result
   int err_count, compares; // Mismatches and comparisons
   logic [1:0] sel_tab [4] = '{2'b00, 2'b10, 2'b11, 2'b01}; // Waveform source codes
   logic [23:0] wave_exp [4] = '{24'h3a5c71, 24'h12ab34, 24'h56cd78, 24'h0}; // Expected sample per code

   srp_link_if link_if();
   srp_device srp_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if), .wave_current(wave_current),
      .wave_voltage(wave_voltage), .wave_power(wave_power), .active_power(active_power),
      .apparent_power(apparent_power), .reactive_power(reactive_power), .energy_tick(energy_tick),
      .half_cycle(half_cycle), .half_cycle_count(half_cycle_count), .operating_mode_q(mode_q));
   srp_host srp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
   srp_link_asserts srp_link_asserts_inst (.pclk(pclk), .presetn(presetn), .sclk(link_if.sclk),
      .cs_n(link_if.cs_n), .din(link_if.din), .dout(link_if.dout), .dout_oe(link_if.dout_oe));

   // Free running bus clock
   always begin
      #5 pclk = ~pclk;
   end

   // Compare and count
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus transfer: setup, then access until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait ends when pready is seen high, or the watchdog fires
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One link frame ordered through the host registers
   task automatic xfer(input logic [7:0] cmd, input logic [1:0] len, input logic [23:0] wd, output logic [23:0] q);
      logic [31:0] r;
      logic e;
      apb(1'b1, SRP_APB_LEN, {30'h0, len}, r, e);
      apb(1'b1, SRP_APB_WDATA, {8'h0, wd}, r, e);
      apb(1'b1, SRP_APB_CMD, {23'h0, 1'b1, cmd}, r, e);
      do begin
         apb(1'b0, SRP_APB_STATUS, 32'h0, r, e);
      end while (r[0] !== 1'b0);
      apb(1'b0, SRP_APB_RDATA, 32'h0, r, e);
      q = r[23:0];
   endtask

   // Verdict and end of run
   task automatic finish_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog against a hung transfer
   initial begin
      #800000;
      err_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      logic [31:0] r32;
      logic e;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, energy_tick, half_cycle} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      {wave_power, wave_current, wave_voltage} = {wave_exp[0], wave_exp[1], wave_exp[2]};
      {active_power, apparent_power, reactive_power} = {24'h5, 24'h7, 24'h9};
      half_cycle_count = 16'h2;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      xfer(8'h09, 2'h2, 24'h0, rd);
      chk(rd, 24'h00000c);
      // Three accumulation ticks of fixed power
      repeat (3) begin
         @(posedge pclk);
         energy_tick <= 1'b1;
         @(posedge pclk);
         energy_tick <= 1'b0;
      end
      // Two half cycles close the line window
      repeat (2) begin
         @(posedge pclk);
         half_cycle <= 1'b1;
         @(posedge pclk);
         half_cycle <= 1'b0;
      end
      xfer(8'h04, 2'h3, 24'h0, rd);
      chk(rd, 24'd15);
      xfer(8'h07, 2'h3, 24'h0, rd);
      chk(rd, 24'd21);
      xfer(8'h08, 2'h3, 24'h0, rd);
      chk(rd, 24'd27);
      xfer(8'h02, 2'h3, 24'h0, rd);
      chk(rd, 24'd15);
      xfer(8'h03, 2'h3, 24'h0, rd);
      chk(rd, 24'd15);
      xfer(8'h03, 2'h3, 24'h0, rd);
      chk(rd, 24'd0);
      xfer(8'h05, 2'h3, 24'h0, rd);
      chk(rd, 24'd21);
      xfer(8'h06, 2'h3, 24'h0, rd);
      chk(rd, 24'd21);
      xfer(8'h06, 2'h3, 24'h0, rd);
      chk(rd, 24'd0);
      xfer(8'h89, 2'h2, 24'h004321, rd);
      chk({8'h0, mode_q}, 24'h004321);
      xfer(8'h09, 2'h2, 24'h0, rd);
      chk(rd, 24'h004321);
      // Every waveform source code in turn
      for (int i = 0; i < 4; i++) begin
         xfer(8'h89, 2'h2, {8'h0, 1'b0, sel_tab[i], 13'h000c}, rd);
         xfer(8'h01, 2'h3, 24'h0, rd);
         chk(rd, wave_exp[i]);
      end
      apb(1'b0, 8'h14, 32'h0, r32, e);
      chk({23'h0, e}, 24'h1);
      finish_test();
   end
endmodule // serial_register_port_tb_top
